// File: rtl/host_serial_register_port.v
// serial host port bridging a host controller to internal registers
`timescale 1ns/1ps
`include "host_serial_port_regs.vh"
`default_nettype none

module host_serial_register_port #(
	parameter LATE_CYCLES = `WR_LATENCY_US * `SYS_CLK_MHZ
) (
	input wire sys_clk, // system clock, 20 MHz
	input wire rst, // synchronous reset, active high
	input wire chip_select_n, // host chip select, active low
	input wire serial_clock, // host serial clock
	input wire command_data, // host command data
	output reg reply_data, // reply data to host
	output reg reply_data_oe, // reply pin driven
	output reg host_interrupt_n_o, // interrupt pin level when driven
	output reg host_interrupt_n_oe, // interrupt pin pulled low
	output reg rd_req, // read request pulse
	output reg [7:0] rd_addr, // read register address
	input wire [15:0] rd_data, // read value, cycle after rd_req
	output reg wr_valid, // written word available
	input wire wr_ready, // written word consumed
	output reg [7:0] wr_addr, // written register address
	output reg [15:0] wr_data, // written register value
	output reg general_reset, // reset command pulse
	output reg write_late, // a write waited past its latency
	output reg write_overrun, // a write was lost to a full queue
	input wire [14:1] status_event, // status condition pulses
	input wire prog_flag // programming flag level
);

// ==========================================
// states
localparam ST_ADDR = 4'b0001;
localparam ST_WDATA = 4'b0010;
localparam ST_RDATA = 4'b0100;
localparam ST_DONE = 4'b1000;

// ==========================================
// decode helpers
function [1:0] len_of;
	input [7:0] a;
	begin
		if (!a[`ADDR_DATA_BIT])
			len_of = 2'd0;
		else if (a[`ADDR_WIDE_BIT])
			len_of = 2'd2;
		else
			len_of = 2'd1;
	end
endfunction

function is_read;
	input [7:0] a;
	begin
		is_read = a[`ADDR_DATA_BIT] && a[`ADDR_READ_BIT];
	end
endfunction

// ==========================================
// pin synchronisers
reg [2:0] pin_s1;
reg [2:0] pin_s2;
reg sclk_d;
wire cs_active;
wire sclk_rise;
wire sclk_fall;
wire mosi;

// two stages for chip select, serial clock, command data
always @(posedge sys_clk)
begin
	if (rst)
	begin
		pin_s1 <= 3'h7;
		pin_s2 <= 3'h7;
		sclk_d <= 1'b1; // matches synchroniser idle, no false edge
	end
	else
	begin
		pin_s1 <= {chip_select_n, serial_clock, command_data};
		pin_s2 <= pin_s1;
		sclk_d <= pin_s2[1];
	end
end

assign cs_active = ~pin_s2[2];
assign sclk_rise = pin_s2[1] & ~sclk_d;
assign sclk_fall = ~pin_s2[1] & sclk_d;
assign mosi = pin_s2[0];

// ==========================================
// byte assembly
reg [3:0] state;
reg [2:0] bit_cnt;
reg [6:0] shreg;
reg [7:0] addr;
reg [1:0] bytes_left;
reg wide;
reg [15:0] wbuf; // last two data bytes, upper first
reg [15:0] rd_shift;
reg rd_phase;
reg rd_load;
reg wr_commit;
reg status_clr;
wire byte_done;
wire [7:0] byte_in;

assign byte_done = cs_active && sclk_rise && (bit_cnt == 3'd7);
assign byte_in = {shreg, mosi};

// ==========================================
// status and mask
reg [15:0] mask;
reg [14:1] flags;
reg irq;
reg prog;
reg [15:0] next_mask;
wire [14:1] flag_rise;
wire mask_hit;

assign flag_rise = status_event & ~flags;
assign mask_hit = |(flag_rise & mask[14:1]) | |((next_mask[14:1] & ~mask[14:1]) & flags);

// ==========================================
// write queue signals
reg pend_valid;
reg [23:0] pend_word;
wire q_in_ready;
wire q_out_valid;
wire q_out_ready;
wire [23:0] q_out_data;

// transaction state machine
always @(posedge sys_clk)
begin
	if (rst || !cs_active)
	begin
		state <= ST_ADDR;
		bit_cnt <= 3'd0;
		shreg <= 7'h00;
		rd_phase <= 1'b0;
		rd_load <= 1'b0;
		wr_commit <= 1'b0;
		status_clr <= 1'b0;
		general_reset <= 1'b0;
		rd_req <= 1'b0;
		if (rst)
		begin
			addr <= 8'h00;
			bytes_left <= 2'd0;
			wide <= 1'b0;
			wbuf <= 16'h0000;
			rd_addr <= 8'h00;
		end
	end
	else
	begin
		rd_req <= 1'b0;
		rd_load <= rd_req;
		wr_commit <= 1'b0;
		status_clr <= 1'b0;
		general_reset <= 1'b0;
		if (sclk_rise)
		begin
			shreg <= byte_in[6:0];
			bit_cnt <= bit_cnt + 3'd1;
		end
		if (byte_done)
		begin
			case (state)
			ST_ADDR:
			begin
				addr <= byte_in;
				bytes_left <= len_of(byte_in);
				wide <= (len_of(byte_in) == 2'd2);
				if (len_of(byte_in) == 2'd0)
				begin
					general_reset <= (byte_in == `CMD_RESET);
					state <= ST_DONE;
				end
				else if (is_read(byte_in))
				begin
					state <= ST_RDATA;
					rd_phase <= 1'b1;
					if (byte_in == `STATUS_ADDR)
						status_clr <= 1'b1;
					else
					begin
						rd_req <= 1'b1;
						rd_addr <= byte_in;
					end
				end
				else
					state <= ST_WDATA;
			end
			ST_WDATA:
			begin
				wbuf <= {wbuf[7:0], byte_in};
				bytes_left <= bytes_left - 2'd1;
				if (bytes_left == 2'd1)
				begin
					wr_commit <= 1'b1;
					state <= ST_DONE;
				end
			end
			ST_RDATA:
			begin
				bytes_left <= bytes_left - 2'd1;
				if (bytes_left == 2'd1)
					state <= ST_DONE;
			end
			ST_DONE:
			begin
				state <= ST_DONE; // extra bytes ignored
			end
			default:
			begin
				state <= ST_ADDR;
			end
			endcase
		end
	end
end

// reply shifter, changes on falling edges so bits hold through high
always @(posedge sys_clk)
begin
	if (rst)
	begin
		rd_shift <= 16'h0000;
		reply_data <= 1'b0;
		reply_data_oe <= 1'b0;
	end
	else
	begin
		reply_data_oe <= cs_active && rd_phase;
		if (status_clr)
			rd_shift <= wide ? {irq, flags, prog} : {flags[7:1], prog, 8'h00};
		else if (rd_load)
			rd_shift <= wide ? rd_data : {rd_data[7:0], 8'h00};
		else if (cs_active && rd_phase && sclk_fall && state == ST_RDATA)
		begin
			reply_data <= rd_shift[15];
			rd_shift <= {rd_shift[14:0], 1'b0};
		end
		if (!cs_active)
			reply_data <= 1'b0;
	end
end

// mask next value from a completed mask write
always @*
begin
	next_mask = mask;
	if (wr_commit && addr == `MASK_ADDR)
		next_mask = wide ? wbuf : {mask[15:8], wbuf[7:0]};
end

// status flags: a new event wins over a read clear
always @(posedge sys_clk)
begin
	if (rst)
	begin
		mask <= `MASK_RESET;
		flags <= `FLAGS_RESET;
		irq <= 1'b0;
		prog <= 1'b0;
		host_interrupt_n_o <= 1'b0;
		host_interrupt_n_oe <= 1'b0;
	end
	else
	begin
		mask <= next_mask;
		prog <= prog_flag; // not cleared by a status read
		flags <= (flags & ~{14{status_clr}}) | status_event;
		irq <= (irq & ~status_clr) | mask_hit;
		host_interrupt_n_o <= 1'b0;
		host_interrupt_n_oe <= irq & mask[`ST_IRQ_BIT];
	end
end

// ==========================================
// write hand-off into the queue
always @(posedge sys_clk)
begin
	if (rst)
	begin
		pend_valid <= 1'b0;
		pend_word <= 24'h000000;
		write_overrun <= 1'b0;
	end
	else
	begin
		if (pend_valid && q_in_ready)
			pend_valid <= 1'b0;
		if (wr_commit && addr != `MASK_ADDR)
		begin
			if (pend_valid && !q_in_ready)
				write_overrun <= 1'b1;
			else
			begin
				pend_valid <= 1'b1;
				pend_word <= {addr, wide ? wbuf : {8'h00, wbuf[7:0]}};
			end
		end
	end
end

word_fifo #(
	.WIDTH(`WQ_WIDTH),
	.DEPTH(`WQ_DEPTH),
	.AW(`WQ_AW)
) u_queue (
	.clk(sys_clk),
	.rst(rst),
	.in_valid(pend_valid),
	.in_ready(q_in_ready),
	.in_data(pend_word),
	.out_valid(q_out_valid),
	.out_ready(q_out_ready),
	.out_data(q_out_data)
);

assign q_out_ready = !wr_valid || wr_ready;

// output stage and latency watch
reg [31:0] wait_cnt;
always @(posedge sys_clk)
begin
	if (rst)
	begin
		wr_valid <= 1'b0;
		wr_addr <= 8'h00;
		wr_data <= 16'h0000;
		wait_cnt <= 32'd0;
		write_late <= 1'b0;
	end
	else
	begin
		if (q_out_ready)
		begin
			wr_valid <= q_out_valid;
			wr_addr <= q_out_data[23:16];
			wr_data <= q_out_data[15:0];
		end
		if (!wr_valid || wr_ready)
			wait_cnt <= 32'd0;
		else
			wait_cnt <= wait_cnt + 32'd1;
		if (wait_cnt >= LATE_CYCLES)
			write_late <= 1'b1;
	end
end

endmodule
`default_nettype wire

// File: rtl/host_serial_port_regs.vh
// constants for the host serial register port
`ifndef HOST_SERIAL_PORT_REGS_VH
`define HOST_SERIAL_PORT_REGS_VH

// ==========================================
// timing
`define SYS_CLK_MHZ 20
`define WR_LATENCY_US 250

// ==========================================
// address decode
`define CMD_RESET 8'h01
`define ADDR_DATA_BIT 7
`define ADDR_WIDE_BIT 6
`define ADDR_READ_BIT 5
`define STATUS_ADDR 8'he6
`define MASK_ADDR 8'hce

// ==========================================
// status and mask layout
`define ST_IRQ_BIT 15
`define ST_PROG_BIT 0
`define STATUS_RESET 16'h0000
`define FLAGS_RESET 14'h0000
`define MASK_RESET 16'h0000

// ==========================================
// write queue
`define WQ_WIDTH 24
`define WQ_DEPTH 8
`define WQ_AW 3

`endif

// File: rtl/word_fifo.v
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk, // system clock
	input wire rst, // synchronous reset, active high
	input wire in_valid, // word offered
	output wire in_ready, // space available
	input wire [WIDTH-1:0] in_data, // word in
	output wire out_valid, // word available
	input wire out_ready, // word taken
	output wire [WIDTH-1:0] out_data // oldest word
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
wire push;
wire pop;

// ==========================================
// flags and handshakes
assign in_ready = (count != DEPTH[AW:0]);
assign out_valid = (count != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

// storage write
always @(posedge clk)
begin
	if (push)
		mem[wr_ptr] <= in_data;
end

// pointers and fill count
always @(posedge clk)
begin
	if (rst)
	begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		count <= {(AW+1){1'b0}};
	end
	else
	begin
		if (push)
			wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
		if (pop)
			rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
		if (push && !pop)
			count <= count + 1'b1;
		else if (pop && !push)
			count <= count - 1'b1;
	end
end

endmodule
`default_nettype wire

// File: tb/host_serial_register_port_sva.sv
// concurrent checks on the serial register port pins
`timescale 1ns/1ps
`default_nettype none
module port_sva (
	input wire logic sys_clk, // clock
	input wire logic rst, // reset
	input wire logic chip_select_n, // select
	input wire logic serial_clock, // link clock
	input wire logic reply_data, // reply
	input wire logic reply_data_oe, // reply on
	input wire logic host_interrupt_n_oe, // irq on
	input wire logic rd_req, // read
	input wire logic [7:0] rd_addr, // read addr
	input wire logic wr_valid, // word out
	input wire logic wr_ready, // taken
	input wire logic [7:0] wr_addr, // write addr
	input wire logic [15:0] wr_data, // write value
	input wire logic general_reset // reset cmd
);
	// one clock domain, reset disables all
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// ==========
	// pin relations
	a_oe_idle: assert property (chip_select_n [*4] |=> !reply_data_oe) else $error("reply on idle");
	a_rd_decode: assert property (rd_req |-> rd_addr[7] && rd_addr[5] && rd_addr != 8'he6) else $error("bad read");
	a_wr_decode: assert property (wr_valid |-> wr_addr[7] && !wr_addr[5] && wr_addr != 8'hce) else $error("bad write");
	a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data})) else $error("word lost");
	a_wr_narrow: assert property (wr_valid && !wr_addr[6] |-> wr_data[15:8] == 8'h00) else $error("wide byte");
	a_reset_pulse: assert property (general_reset |=> !general_reset) else $error("long reset");
	a_irq_clear: assert property ($fell(host_interrupt_n_oe) && !$past(rst) |-> !$past(chip_select_n, 8)) else $error("irq drop");
	a_reply_time: assert property (reply_data_oe && $changed(reply_data) |-> !$past(serial_clock, 2)) else $error("reply late");
endmodule
bind host_serial_register_port port_sva port_sva_i (.*);
`default_nettype wire

// File: tb/host_master_model.sv
// host-side serial master model driving the port pins
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
	input wire logic sys_clk, // time base
	input wire logic reply_pin, // reply line
	output var logic chip_select_n, // select
	output var logic serial_clock, // link clock
	output var logic command_data // command data
);
	// idle pins
	initial
	begin
		chip_select_n = 1'h1;
		serial_clock = 1'h0;
		command_data = 1'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// ==========
	// address then data, msb first; reply taken at end of high half
	task automatic frame(input logic [7:0] a, input logic [15:0] d, input int nd, input int cut,
		output logic [15:0] rx);
		logic [23:0] sh;
		int n;
		sh = nd == 1 ? {a, d[7:0], 8'h00} : {a, d};
		n = cut != 0 ? cut : 8 * nd + 8;
		rx = 16'h0000;
		chip_select_n <= 1'h0;
		tick(4);
		for (int i = 0; i < n; i++)
		begin
			if (i % 8 == 0) tick(i == 0 ? 0 : 5 * ($urandom % 2));
			serial_clock <= 1'h0;
			command_data <= sh[23 - i];
			tick(4);
			serial_clock <= 1'h1;
			tick(4);
			rx = {rx[14:0], reply_pin};
		end
		if ($urandom % 2) serial_clock <= 1'h0;
		tick(4);
		chip_select_n <= 1'h1;
		command_data <= ~command_data;
		tick(8);
	endtask
endmodule
`default_nettype wire

// File: tb/host_serial_register_port_tb.sv
// self-checking bench for the host serial register port
`timescale 1ns/1ps
`default_nettype none
module host_serial_register_port_tb;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic wr_ready = 1'h0;
	logic stall = 1'h0;
	logic prog_flag = 1'h1;
	logic [15:0] rd_data = 16'h0000;
	logic [14:1] status_event = 14'h0000;
	logic chip_select_n, serial_clock, command_data, reply_data, reply_data_oe, reply_pin, irq_pin;
	logic host_interrupt_n_o, host_interrupt_n_oe, rd_req, wr_valid, general_reset, write_late, write_overrun;
	logic [7:0] rd_addr, wr_addr, a;
	logic [15:0] wr_data, rx;
	logic [23:0] expq[$];
	int n_errors = 0;
	int check_count = 0;
	int n_rd = 0;
	int n_rst = 0;
	// ==========
	// clock, pins and instances
	always #25 sys_clk = ~sys_clk;
	assign reply_pin = reply_data_oe ? reply_data : ~reply_data; // released line shows no stale bit
	assign irq_pin = host_interrupt_n_oe ? host_interrupt_n_o : 1'h1; // pull-up
	host_serial_register_port #(.LATE_CYCLES(50)) host_serial_register_port_i (.*);
	host_master_model host_master_model_i (.*);
	// compare and count
	task automatic check(input logic ok, input string what);
		check_count++;
		if (ok !== 1'h1)
		begin
			n_errors++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one frame; a kept write goes into the model queue
	task automatic xf(input logic [7:0] xa, input logic [15:0] d, input int nd, input int cut, input logic keep);
		if (keep) expq.push_back({xa, nd == 2 ? d : {8'h00, d[7:0]}});
		host_master_model_i.frame(xa, d, nd, cut, rx);
	endtask
	task automatic pulse(input logic [14:1] ev);
		status_event <= ev;
		@(posedge sys_clk);
		status_event <= 14'h0000;
		repeat (10) @(posedge sys_clk);
	endtask
	// consumer with random stalls, write compare, pulse counts
	always @(posedge sys_clk)
	begin
		wr_ready <= !stall && $urandom % 4 != 0;
		if (!rst && wr_valid && wr_ready)
		begin
			if (expq.size() != 0)
				check({wr_addr, wr_data} === expq.pop_front(), "write word");
			else
				check(1'h0, "stray write");
		end
		if (rd_req === 1'h1) n_rd++;
		if (general_reset === 1'h1) n_rst++;
	end
	// ==========
	// scenarios
	initial
	begin
		void'($urandom(19));
		repeat (5) @(posedge sys_clk);
		rst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 6; i++)
		begin
			a = {2'h2 | 2'(i % 2), 1'h0, 5'($urandom)};
			if (a == 8'hce) a = 8'hcf;
			xf(a, 16'($urandom), 1 + i % 2, 0, 1'h1);
		end
		xf(8'hc0, 16'h1234, 2, 20, 1'h0);
		xf(8'h85, 16'h0000, 0, 4, 1'h0);
		xf(8'h81, 16'h005a, 1, 0, 1'h1);
		repeat (100) @(posedge sys_clk);
		check(expq.size() == 0 && write_late === 1'h0, "writes taken");
		xf(8'h02, 16'h0000, 0, 0, 1'h0);
		xf(8'h01, 16'h0000, 0, 0, 1'h0);
		check(n_rst == 1, "reset command");
		for (int i = 1; i < 3; i++)
		begin
			rd_data <= 16'($urandom);
			xf(i == 2 ? 8'he1 : 8'ha3, 16'($urandom), i, 0, 1'h0);
			check(rx[7:0] === rd_data[7:0] && (i == 1 || rx === rd_data), "read data");
			check(rd_addr === (i == 2 ? 8'he1 : 8'ha3), "read address");
		end
		check(n_rd == 2, "read requests");
		xf(8'hce, 16'h8002, 2, 0, 1'h0);
		pulse(14'h0002);
		check(irq_pin === 1'h1, "masked irq");
		pulse(14'h0001);
		check(irq_pin === 1'h0, "irq");
		xf(8'he6, 16'($urandom), 2, 0, 1'h0);
		check(rx === 16'h8007 && irq_pin === 1'h1, "status");
		xf(8'he6, 16'($urandom), 2, 0, 1'h0);
		check(rx === 16'h0001, "status cleared");
		// flag set first, mask enabled afterwards still raises the request
		pulse(14'h0004);
		check(irq_pin === 1'h1, "flag before mask");
		xf(8'hce, 16'h8008, 2, 0, 1'h0);
		check(irq_pin === 1'h0, "late mask irq");
		xf(8'he6, 16'($urandom), 2, 0, 1'h0);
		check(rx === 16'h8009 && irq_pin === 1'h1, "late mask status");
		// output stage, eight queue words and the pending slot hold ten writes
		stall <= 1'h1;
		for (int i = 0; i < 12; i++)
			xf(8'h81, 16'(i), 1, 0, i < 10);
		check(write_overrun === 1'h1 && write_late === 1'h1, "full queue");
		stall <= 1'h0;
		repeat (200) @(posedge sys_clk);
		check(expq.size() == 0, "queue drained");
		end_of_test;
	end
	// hang guard
	initial
	begin
		#2000000;
		n_errors++;
		$display("Error at %0t: timeout", $time);
		end_of_test;
	end
endmodule
`default_nettype wire
